/* File: rtl/partition_select_priority_cfg.sv */
// partition selector and per-partition priority registers, secure and non-secure pages
// assumes one request per cycle at most, taken the cycle it is presented
//
// Operation
// - 16-bit partition selector field picks the partition for later control accesses.
// - 4-bit instance selector picks the resource when supported, else reads zero.
// - without narrowing the internal bit reads zero and ignores writes.
// - internal bit clear: selector is a request partition, only for mapping register.
// - internal bit set: selector is an internal partition for other control accesses.
// - mapping register access with internal bit set raises unexpected-internal error.
// - other control access with narrowing and internal bit clear raises range error.
// - on selector errors read data is arbitrary and stored settings stay unchanged.
// - secure and non-secure pages have separate selectors in their own space.
// - upper field holds downstream priority when supported, else reads zero.
// - lower field holds internal priority when supported, else reads zero.
// - only the configured downstream width is kept, in the low bits.
// - only the configured internal width is kept, in the low bits.
// - zero-is-lowest flags set how each priority value is ranked.
// - priority accesses reach the chosen instance and partition.
// - without priority partitioning the priority location reads zero, ignores writes.
`timescale 1ns/1ns
module partition_select_priority_cfg #(
  parameter bit INSTANCE_SELECT_SUPPORTED       = 1'b1,
  parameter int NUM_INSTANCES                   = 2,
  parameter int NUM_PARTITIONS                  = 16,
  parameter bit NARROWING_SUPPORTED             = 1'b1,
  parameter bit PRIORITY_PARTITIONING_SUPPORTED = 1'b1,
  parameter bit DOWNSTREAM_PRIORITY_SUPPORTED   = 1'b1,
  parameter bit INTERNAL_PRIORITY_SUPPORTED     = 1'b1,
  parameter int DOWNSTREAM_PRIORITY_WIDTH       = 4,
  parameter int INTERNAL_PRIORITY_WIDTH         = 4,
  parameter bit DOWNSTREAM_ZERO_IS_LOWEST       = 1'b1,
  parameter bit INTERNAL_ZERO_IS_LOWEST         = 1'b1
) (
  // clock and reset
  input  wire logic                           i_clk,
  input  wire logic                           i_rst_n,
  // register access from the feature pages
  input  wire logic                           i_req_valid,
  input  wire partition_cfg_pkg::reg_req_t    i_req,
  output      logic                           o_ack,
  output      logic [31:0]                    o_rdata,
  // error report toward the error status register
  output      logic                           o_error_valid,
  output      partition_cfg_pkg::error_code_t o_error_code,
  output      logic                           o_error_secure,
  // priority lookup for traffic
  input  wire logic                           i_lookup_valid,
  input  wire partition_cfg_pkg::lookup_req_t i_lookup,
  output      logic                           o_lookup_valid,
  output      partition_cfg_pkg::priority_pair_t o_lookup_pri,
  output      partition_cfg_pkg::priority_pair_t o_lookup_rank
);

  // ----------------------------------------------------------------
  // sizing and masks
  // ----------------------------------------------------------------
  localparam int RIW   = (NUM_INSTANCES > 1) ? $clog2(NUM_INSTANCES) : 1;
  localparam int PIW   = (NUM_PARTITIONS > 1) ? $clog2(NUM_PARTITIONS) : 1;
  localparam int AW    = 1 + RIW + PIW;
  localparam int DEPTH = 2 ** AW;

  // reserved selector bits are dropped at write time so they always read zero
  localparam logic [31:0] SEL_WMASK = partition_cfg_pkg::SEL_PARTITION_IDENTIFIER_MASK
    | (NARROWING_SUPPORTED ? partition_cfg_pkg::SEL_INTERNAL_MASK : 32'h0000_0000)
    | (INSTANCE_SELECT_SUPPORTED ? partition_cfg_pkg::SEL_RIS_MASK : 32'h0000_0000);

  localparam logic [15:0] DS_MASK = DOWNSTREAM_PRIORITY_SUPPORTED ?
    16'((17'h0_0001 << DOWNSTREAM_PRIORITY_WIDTH) - 17'h0_0001) : 16'h0000;
  localparam logic [15:0] INT_MASK = INTERNAL_PRIORITY_SUPPORTED ?
    16'((17'h0_0001 << INTERNAL_PRIORITY_WIDTH) - 17'h0_0001) : 16'h0000;

  // ----------------------------------------------------------------
  // selector registers, one per security space
  // ----------------------------------------------------------------
  logic [31:0] sel_secure;
  logic [31:0] sel_nonsecure;
  logic [31:0] cur_sel;
  logic        cur_internal;
  logic [15:0] cur_partition_identifier;
  logic [3:0]  cur_ris;
  logic        cur_in_range;
  logic        is_sel;
  logic        is_pri;
  logic        is_map;
  logic        take;
  partition_cfg_pkg::error_code_t next_err;
  logic [AW-1:0] cfg_index;
  logic [AW-1:0] lookup_index;
  logic          store_wr;
  logic [31:0]   store_wdata;
  logic [31:0]   store_rdata_a;
  logic [31:0]   store_rdata_b;

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  // every request is taken, the bank never stalls
  assign take   = i_req_valid;
  assign is_sel = (i_req.addr == partition_cfg_pkg::SELECTOR_OFFSET);
  assign is_pri = PRIORITY_PARTITIONING_SUPPORTED
                  && (i_req.addr == partition_cfg_pkg::PRIORITY_OFFSET);
  // mapping contents live outside; decoded only to check the internal bit
  assign is_map = NARROWING_SUPPORTED && (i_req.addr == partition_cfg_pkg::MAPPING_OFFSET);

  // the page that carries the access picks its own selector
  assign cur_sel      = i_req.secure ? sel_secure : sel_nonsecure;
  assign cur_internal = cur_sel[partition_cfg_pkg::SEL_INTERNAL_BIT];
  assign cur_partition_identifier   = cur_sel[partition_cfg_pkg::SEL_PARTITION_IDENTIFIER_MSB:
                                partition_cfg_pkg::SEL_PARTITION_IDENTIFIER_LSB];
  assign cur_ris      = cur_sel[partition_cfg_pkg::SEL_RIS_MSB:partition_cfg_pkg::SEL_RIS_LSB];
  // selectors past the implemented storage are reported as range errors
  assign cur_in_range = (32'(cur_partition_identifier) < NUM_PARTITIONS)
                        && (32'(cur_ris) < NUM_INSTANCES);

  // ----------------------------------------------------------------
  // selector error check
  // ----------------------------------------------------------------
  // the mapping test comes first; the two errors never apply together
  always_comb
  begin
    next_err = partition_cfg_pkg::ERR_NONE;
    if (is_map && cur_internal)
    begin
      next_err = partition_cfg_pkg::ERR_UNEXPECTED_INTERNAL;
    end
    else if (is_pri && ((NARROWING_SUPPORTED && !cur_internal) || !cur_in_range))
    begin
      next_err = partition_cfg_pkg::ERR_INTERNAL_PARTITION_RANGE;
    end
  end

  // ----------------------------------------------------------------
  // selector write
  // ----------------------------------------------------------------
  // both pages restart on partition zero of instance zero
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      sel_secure    <= partition_cfg_pkg::SELECTOR_RESET;
      sel_nonsecure <= partition_cfg_pkg::SELECTOR_RESET;
    end
    else if (take && i_req.write && is_sel)
    begin
      if (i_req.secure)
      begin
        sel_secure <= i_req.wdata & SEL_WMASK;
      end
      else
      begin
        sel_nonsecure <= i_req.wdata & SEL_WMASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // per-partition priority storage
  // ----------------------------------------------------------------
  // high selector bits never alias: out-of-range selectors error before any write
  assign cfg_index = {i_req.secure, cur_ris[RIW-1:0], cur_partition_identifier[PIW-1:0]};
  // lookups own the second read port, so traffic never waits on software
  assign lookup_index = {i_lookup.secure, i_lookup.instance_sel[RIW-1:0],
                         i_lookup.partition[PIW-1:0]};

  // an erroring write never reaches storage
  assign store_wr = take && i_req.write && is_pri
                    && (next_err == partition_cfg_pkg::ERR_NONE);
  assign store_wdata = {i_req.wdata[partition_cfg_pkg::PRI_DS_MSB:partition_cfg_pkg::PRI_DS_LSB]
                        & DS_MASK,
                        i_req.wdata[partition_cfg_pkg::PRI_INT_MSB:partition_cfg_pkg::PRI_INT_LSB]
                        & INT_MASK};

  priority_store #(
    .DEPTH (DEPTH),
    .AW    (AW),
    .W     (32)
  ) u_store (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_wr_en     (store_wr),
    .i_wr_addr   (cfg_index),
    .i_wr_data   (store_wdata),
    .i_rd_addr_a (cfg_index),
    .o_rd_data_a (store_rdata_a),
    .i_rd_addr_b (lookup_index),
    .o_rd_data_b (store_rdata_b)
  );

  // ----------------------------------------------------------------
  // first answer stage, waits for the store read
  // ----------------------------------------------------------------
  // decode and store read fill one cycle, the output registers the next
  logic                           s1_valid;
  logic                           s1_read_pri;
  logic [31:0]                    s1_direct;
  logic                           s1_secure;
  partition_cfg_pkg::error_code_t s1_err;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      s1_valid    <= 1'b0;
      s1_read_pri <= 1'b0;
      s1_direct   <= 32'h0000_0000;
      s1_secure   <= 1'b0;
      s1_err      <= partition_cfg_pkg::ERR_NONE;
    end
    else
    begin
      s1_valid    <= take;
      s1_read_pri <= take && !i_req.write && is_pri
                     && (next_err == partition_cfg_pkg::ERR_NONE);
      // mapping register contents live elsewhere; unmapped reads give zero
      s1_direct   <= (take && !i_req.write && is_sel) ? cur_sel : 32'h0000_0000;
      s1_secure   <= i_req.secure;
      s1_err      <= take ? next_err : partition_cfg_pkg::ERR_NONE;
    end
  end

  // ----------------------------------------------------------------
  // answer and error report
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_ack   <= 1'b0;
      o_rdata <= 32'h0000_0000;
    end
    else
    begin
      o_ack   <= s1_valid;
      // erroring reads return zero, which is one of the allowed values
      o_rdata <= s1_read_pri ? store_rdata_a : s1_direct;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_error_valid  <= 1'b0;
      o_error_code   <= partition_cfg_pkg::ERR_NONE;
      o_error_secure <= 1'b0;
    end
    else
    begin
      o_error_valid  <= s1_valid && (s1_err != partition_cfg_pkg::ERR_NONE);
      o_error_code   <= s1_valid ? s1_err : partition_cfg_pkg::ERR_NONE;
      o_error_secure <= s1_secure;
    end
  end

  // ----------------------------------------------------------------
  // traffic lookup, rank makes a larger value always more urgent
  // ----------------------------------------------------------------
  logic                              lk_valid;
  logic                              lk_in_range;
  partition_cfg_pkg::priority_pair_t lk_raw;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      lk_valid    <= 1'b0;
      lk_in_range <= 1'b0;
    end
    else
    begin
      lk_valid    <= i_lookup_valid;
      lk_in_range <= (32'(i_lookup.partition) < NUM_PARTITIONS)
                     && (32'(i_lookup.instance_sel) < NUM_INSTANCES);
    end
  end

  // out-of-range lookups see zero, never an aliased entry
  assign lk_raw = lk_in_range ? store_rdata_b : partition_cfg_pkg::PRIORITY_RESET;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_lookup_valid <= 1'b0;
      o_lookup_pri   <= partition_cfg_pkg::PRIORITY_RESET;
      o_lookup_rank  <= partition_cfg_pkg::PRIORITY_RESET;
    end
    else
    begin
      o_lookup_valid <= lk_valid;
      o_lookup_pri   <= lk_raw;
      o_lookup_rank.ds_pri  <= DOWNSTREAM_ZERO_IS_LOWEST ? lk_raw.ds_pri
                                                         : (~lk_raw.ds_pri & DS_MASK);
      o_lookup_rank.int_pri <= INTERNAL_ZERO_IS_LOWEST ? lk_raw.int_pri
                                                       : (~lk_raw.int_pri & INT_MASK);
    end
  end

endmodule

/* File: rtl/partition_cfg_pkg.sv */
// constants, types and register layout for the partition selector and priority bank
// assumes a feature page frame of 4 KiB decoded by the surrounding fabric
package partition_cfg_pkg;

  // ----------------------------------------------------------------
  // register offsets inside one feature page
  // ----------------------------------------------------------------
  localparam logic [11:0] SELECTOR_OFFSET = 12'h100;
  localparam logic [11:0] PRIORITY_OFFSET = 12'h400;
  localparam logic [11:0] MAPPING_OFFSET  = 12'h600;

  // ----------------------------------------------------------------
  // selector field layout
  // ----------------------------------------------------------------
  localparam int          SEL_PARTITION_IDENTIFIER_LSB    = 0;
  localparam int          SEL_PARTITION_IDENTIFIER_MSB    = 15;
  localparam int          SEL_INTERNAL_BIT  = 16;
  localparam int          SEL_RIS_LSB       = 24;
  localparam int          SEL_RIS_MSB       = 27;
  localparam logic [31:0] SEL_PARTITION_IDENTIFIER_MASK   = 32'h0000_ffff;
  localparam logic [31:0] SEL_INTERNAL_MASK = 32'h0001_0000;
  localparam logic [31:0] SEL_RIS_MASK      = 32'h0f00_0000;
  localparam logic [31:0] SELECTOR_RESET    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // priority field layout
  // ----------------------------------------------------------------
  localparam int          PRI_INT_LSB    = 0;
  localparam int          PRI_INT_MSB    = 15;
  localparam int          PRI_DS_LSB     = 16;
  localparam int          PRI_DS_MSB     = 31;
  localparam logic [31:0] PRIORITY_RESET = 32'h0000_0000;
  localparam int          PRI_FIELD_W    = 16;

  // ----------------------------------------------------------------
  // answer latency of every register access and lookup, in cycles
  // ----------------------------------------------------------------
  localparam int ACCESS_LATENCY = 2;

  typedef enum logic [1:0] {
    ERR_NONE,
    ERR_UNEXPECTED_INTERNAL,
    ERR_INTERNAL_PARTITION_RANGE
  } error_code_t;

  typedef struct packed {
    logic        write;
    logic        secure;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        secure;
    logic [3:0]  instance_sel;
    logic [15:0] partition;
  } lookup_req_t;

  typedef struct packed {
    logic [15:0] ds_pri;
    logic [15:0] int_pri;
  } priority_pair_t;

endpackage

/* File: rtl/priority_store.sv */
// per-partition priority storage, one write port and two registered read ports
// assumes the caller keeps every address below DEPTH
`timescale 1ns/1ns
module priority_store #(
  parameter int DEPTH = 64,
  parameter int AW    = 6,
  parameter int W     = 32
) (
  // clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  // write port
  input  wire logic          i_wr_en,
  input  wire logic [AW-1:0] i_wr_addr,
  input  wire logic [W-1:0]  i_wr_data,
  // read ports
  input  wire logic [AW-1:0] i_rd_addr_a,
  output      logic [W-1:0]  o_rd_data_a,
  input  wire logic [AW-1:0] i_rd_addr_b,
  output      logic [W-1:0]  o_rd_data_b
);

  logic [W-1:0] mem [DEPTH];

  // cleared on reset so no partition starts with stale priority
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= '0;
      end
    end
    else if (i_wr_en)
    begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_rd_data_a <= '0;
      o_rd_data_b <= '0;
    end
    else
    begin
      o_rd_data_a <= mem[i_rd_addr_a];
      o_rd_data_b <= mem[i_rd_addr_b];
    end
  end

endmodule

/* File: verif/partition_cfg_properties.sv */
// assertions on the ports of the partition selector and priority bank
// assumes it is bound to every instance of that bank
`timescale 1ns/1ns
module partition_cfg_properties #(
  parameter int DOWNSTREAM_PRIORITY_WIDTH = 4,
  parameter int INTERNAL_PRIORITY_WIDTH   = 4,
  parameter bit DOWNSTREAM_ZERO_IS_LOWEST = 1'b1,
  parameter bit INTERNAL_ZERO_IS_LOWEST   = 1'b1
) (
  // clock and reset
  input wire logic                              i_clk,
  input wire logic                              i_rst_n,
  // register access
  input wire logic                              i_req_valid,
  input wire partition_cfg_pkg::reg_req_t       i_req,
  input wire logic                              o_ack,
  input wire logic [31:0]                       o_rdata,
  input wire logic                              o_error_valid,
  input wire partition_cfg_pkg::error_code_t    o_error_code,
  input wire logic                              o_error_secure,
  // priority lookup
  input wire logic                              i_lookup_valid,
  input wire partition_cfg_pkg::lookup_req_t    i_lookup,
  input wire logic                              o_lookup_valid,
  input wire partition_cfg_pkg::priority_pair_t o_lookup_pri,
  input wire partition_cfg_pkg::priority_pair_t o_lookup_rank
);
  // a width of zero stands for an unsupported field
  localparam logic [15:0] ds_mask = 16'((32'h0000_0001 << DOWNSTREAM_PRIORITY_WIDTH) - 1);
  localparam logic [15:0] in_mask = 16'((32'h0000_0001 << INTERNAL_PRIORITY_WIDTH) - 1);
  localparam logic [15:0] ds_flip = DOWNSTREAM_ZERO_IS_LOWEST ? 16'h0000 : ds_mask;
  localparam logic [15:0] in_flip = INTERNAL_ZERO_IS_LOWEST ? 16'h0000 : in_mask;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_ack_two_cycles: assert property (i_req_valid |-> ##2 o_ack)
    else $error("ack missing two cycles after request");
  a_ack_has_cause: assert property (o_ack |-> $past(i_req_valid, 2))
    else $error("ack without request");
  a_write_reads_zero: assert property (i_req_valid && i_req.write |-> ##2 o_rdata == '0)
    else $error("write answered with data");
  a_error_with_ack: assert property (o_error_valid |-> o_ack
    && o_error_code != partition_cfg_pkg::ERR_NONE)
    else $error("error report outside an answer");
  a_error_reads_zero: assert property (o_error_valid |-> o_rdata == '0)
    else $error("erroring access returned data");
  a_error_page: assert property (o_ack |-> o_error_secure == $past(i_req.secure, 2))
    else $error("answer page differs from request page");
  a_lookup_latency: assert property (i_lookup_valid |-> ##2 o_lookup_valid)
    else $error("lookup answer late");
  a_priority_widths: assert property (o_lookup_valid |->
    ((o_lookup_pri.ds_pri & ~ds_mask) == '0) && ((o_lookup_pri.int_pri & ~in_mask) == '0))
    else $error("priority bits beyond implemented width");
  a_rank_order: assert property (o_lookup_valid |->
    o_lookup_rank.ds_pri == (o_lookup_pri.ds_pri ^ ds_flip)
    && o_lookup_rank.int_pri == (o_lookup_pri.int_pri ^ in_flip))
    else $error("rank does not follow polarity");
endmodule

/* File: verif/tb_partition_select_priority_cfg.sv */
// self-checking bench for the partition selector and priority bank
// assumes answers come two cycles after the request
// dut2 lacks narrowing, instances and downstream priority; dut3 lacks priority partitioning
`timescale 1ns/1ns
module tb_partition_select_priority_cfg;
  typedef struct {
    logic [31:0]                    rd;
    logic                           ev;
    partition_cfg_pkg::error_code_t code;
    logic                           sec;
  } expect_t;
  localparam logic [11:0] sel_a = partition_cfg_pkg::SELECTOR_OFFSET;
  localparam logic [11:0] pri_a = partition_cfg_pkg::PRIORITY_OFFSET;
  localparam logic [11:0] map_a = partition_cfg_pkg::MAPPING_OFFSET;
  localparam partition_cfg_pkg::error_code_t eu = partition_cfg_pkg::ERR_UNEXPECTED_INTERNAL;
  localparam partition_cfg_pkg::error_code_t er = partition_cfg_pkg::ERR_INTERNAL_PARTITION_RANGE;
  logic                              i_clk          = 1'b0;
  logic                              i_rst_n        = 1'b0;
  logic                              i_req_valid    = 1'b0;
  partition_cfg_pkg::reg_req_t       i_req          = '0;
  logic                              i_lookup_valid = 1'b0;
  partition_cfg_pkg::lookup_req_t    i_lookup       = '0;
  logic [2:0]                        ack, err_v, err_s, lk_v;
  logic [31:0]                       rdata [3];
  partition_cfg_pkg::error_code_t    code [3];
  partition_cfg_pkg::priority_pair_t pri [3];
  partition_cfg_pkg::priority_pair_t rank [3];
  expect_t                           exp_q [$];
  expect_t                           e;
  int                                tgt         = 0;
  int                                num_errors  = 0;
  int                                checks_done = 0;

  always #5 i_clk = ~i_clk;

  partition_select_priority_cfg dut (.i_clk, .i_rst_n, .i_req_valid, .i_req, .o_ack(ack[0]),
    .o_rdata(rdata[0]), .o_error_valid(err_v[0]), .o_error_code(code[0]),
    .o_error_secure(err_s[0]), .i_lookup_valid, .i_lookup, .o_lookup_valid(lk_v[0]),
    .o_lookup_pri(pri[0]), .o_lookup_rank(rank[0]));
  partition_select_priority_cfg #(.INSTANCE_SELECT_SUPPORTED(1'b0), .NARROWING_SUPPORTED(1'b0),
    .DOWNSTREAM_PRIORITY_SUPPORTED(1'b0),
    .DOWNSTREAM_ZERO_IS_LOWEST(1'b0), .INTERNAL_ZERO_IS_LOWEST(1'b0)) dut2 (.i_clk, .i_rst_n,
    .i_req_valid, .i_req, .o_ack(ack[1]), .o_rdata(rdata[1]), .o_error_valid(err_v[1]),
    .o_error_code(code[1]), .o_error_secure(err_s[1]), .i_lookup_valid, .i_lookup,
    .o_lookup_valid(lk_v[1]), .o_lookup_pri(pri[1]), .o_lookup_rank(rank[1]));
  partition_select_priority_cfg #(.PRIORITY_PARTITIONING_SUPPORTED(1'b0)) dut3 (.i_clk, .i_rst_n,
    .i_req_valid, .i_req, .o_ack(ack[2]), .o_rdata(rdata[2]), .o_error_valid(err_v[2]),
    .o_error_code(code[2]), .o_error_secure(err_s[2]), .i_lookup_valid, .i_lookup,
    .o_lookup_valid(lk_v[2]), .o_lookup_pri(pri[2]), .o_lookup_rank(rank[2]));

  task automatic cmp_word(input string name, input logic [31:0] ex, input logic [31:0] g);
    checks_done++;
    if (g !== ex)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, ex, g);
    end
  endtask

  task automatic cmp_bit(input string name, input logic ex, input logic g);
    checks_done++;
    if (g !== ex)
    begin
      num_errors++;
      $display("[ERR] %s expected %b seen %b", name, ex, g);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // register access and answer checking
  // ----------------------------------------------------------------
  // requests may follow every cycle, so answers are matched from a queue
  task automatic req(input logic w, input logic s, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] rd, input logic ev,
                     input partition_cfg_pkg::error_code_t c);
    @(negedge i_clk);
    i_req_valid = 1'b1;
    i_req = '{w, s, a, d};
    exp_q.push_back('{rd, ev, c, s});
  endtask

  task automatic wr(input logic s, input logic [11:0] a, input logic [31:0] d);
    req(1'b1, s, a, d, 32'h0000_0000, 1'b0, partition_cfg_pkg::ERR_NONE);
  endtask

  task automatic rd(input logic s, input logic [11:0] a, input logic [31:0] ex);
    req(1'b0, s, a, 32'h0000_0000, ex, 1'b0, partition_cfg_pkg::ERR_NONE);
  endtask

  task automatic drain(input string name);
    int n;
    @(negedge i_clk);
    i_req_valid = 1'b0;
    for (n = 0; n < 8 && exp_q.size() != 0; n++)
      @(negedge i_clk);
    cmp_bit("all answers seen", 1'b1, exp_q.size() == 0);
    exp_q.delete();
    $display("test %s done", name);
  endtask

  always @(negedge i_clk)
  begin
    if (ack[tgt] === 1'b1)
    begin
      if (exp_q.size() == 0)
        cmp_bit("ack expected", 1'b0, 1'b1);
      else
      begin
        e = exp_q.pop_front();
        cmp_word("read data", e.rd, rdata[tgt]);
        cmp_bit("error flag", e.ev, err_v[tgt]);
        cmp_word("error code", {30'h0, e.code}, {30'h0, code[tgt]});
        cmp_bit("error page", e.sec, err_s[tgt]);
      end
    end
  end

  task automatic look(input logic s, input logic [3:0] inst, input logic [15:0] p,
                      input logic [31:0] ep, input logic [31:0] erk);
    int n;
    @(negedge i_clk);
    i_lookup_valid = 1'b1;
    i_lookup = '{s, inst, p};
    @(negedge i_clk);
    i_lookup_valid = 1'b0;
    for (n = 0; n < 4 && lk_v[tgt] !== 1'b1; n++)
      @(negedge i_clk);
    cmp_bit("lookup valid", 1'b1, lk_v[tgt]);
    cmp_word("lookup priority", ep, pri[tgt]);
    cmp_word("lookup rank", erk, rank[tgt]);
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(negedge i_clk);
    i_rst_n = 1'b1;
    rd(1'b0, sel_a, 32'h0000_0000);
    rd(1'b1, sel_a, 32'h0000_0000);
    wr(1'b0, sel_a, 32'hffff_ffff);
    rd(1'b0, sel_a, 32'h0f01_ffff);
    rd(1'b1, sel_a, 32'h0000_0000);
    rd(1'b0, 12'h004, 32'h0000_0000);
    drain("selector");
    wr(1'b0, sel_a, 32'h0000_0003);
    req(1'b1, 1'b0, pri_a, 32'h0005_0006, 32'h0000_0000, 1'b1, er);
    rd(1'b0, map_a, 32'h0000_0000);
    wr(1'b0, sel_a, 32'h0001_0003);
    rd(1'b0, pri_a, 32'h0000_0000);
    req(1'b0, 1'b0, map_a, 32'h0000_0000, 32'h0000_0000, 1'b1, eu);
    wr(1'b0, pri_a, 32'habcd_1234);
    rd(1'b0, pri_a, 32'h000d_0004);
    drain("selector errors");
    wr(1'b1, sel_a, 32'h0001_0003);
    rd(1'b1, pri_a, 32'h0000_0000);
    wr(1'b1, pri_a, 32'h0002_0007);
    wr(1'b0, sel_a, 32'h0101_0003);
    rd(1'b0, pri_a, 32'h0000_0000);
    wr(1'b0, pri_a, 32'h0001_0001);
    wr(1'b0, sel_a, 32'h0001_0010);
    req(1'b1, 1'b0, pri_a, 32'h0003_0003, 32'h0000_0000, 1'b1, er);
    wr(1'b0, sel_a, 32'h0201_0003);
    req(1'b0, 1'b0, pri_a, 32'h0000_0000, 32'h0000_0000, 1'b1, er);
    drain("spaces and instances");
    look(1'b0, 4'h0, 16'h0003, 32'h000d_0004, 32'h000d_0004);
    look(1'b1, 4'h0, 16'h0003, 32'h0002_0007, 32'h0002_0007);
    look(1'b0, 4'h1, 16'h0003, 32'h0001_0001, 32'h0001_0001);
    look(1'b0, 4'h0, 16'h0010, 32'h0000_0000, 32'h0000_0000);
    look(1'b0, 4'h0, 16'h0000, 32'h0000_0000, 32'h0000_0000);
    $display("test lookups done");
    tgt = 1;
    wr(1'b0, sel_a, 32'hffff_0002);
    rd(1'b0, sel_a, 32'h0000_0002);
    wr(1'b0, pri_a, 32'h0003_0005);
    rd(1'b0, pri_a, 32'h0000_0005);
    drain("without narrowing");
    look(1'b0, 4'h0, 16'h0002, 32'h0000_0005, 32'h0000_000a);
    $display("test inverted rank done");
    tgt = 2;
    wr(1'b0, sel_a, 32'h0001_0001);
    wr(1'b0, pri_a, 32'h0003_0003);
    rd(1'b0, pri_a, 32'h0000_0000);
    drain("without priority partitioning");
    look(1'b0, 4'h0, 16'h0001, 32'h0000_0000, 32'h0000_0000);
    print_verdict();
  end

  initial
  begin
    #20000;
    num_errors++;
    print_verdict();
  end
endmodule

bind partition_select_priority_cfg partition_cfg_properties #(
  .DOWNSTREAM_PRIORITY_WIDTH(DOWNSTREAM_PRIORITY_SUPPORTED ? DOWNSTREAM_PRIORITY_WIDTH : 0),
  .INTERNAL_PRIORITY_WIDTH(INTERNAL_PRIORITY_SUPPORTED ? INTERNAL_PRIORITY_WIDTH : 0),
  .DOWNSTREAM_ZERO_IS_LOWEST(DOWNSTREAM_ZERO_IS_LOWEST),
  .INTERNAL_ZERO_IS_LOWEST(INTERNAL_ZERO_IS_LOWEST)
) u_props (.i_clk, .i_rst_n, .i_req_valid, .i_req, .o_ack, .o_rdata, .o_error_valid,
  .o_error_code, .o_error_secure, .i_lookup_valid, .i_lookup, .o_lookup_valid, .o_lookup_pri,
  .o_lookup_rank);
